// ### cpt_pkg.sv
/*
  Constants for the compact timer: register offsets, field positions,
  reset values, mode and pin-action encodings and clock-source codes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none

package cpt_pkg;

  // =====================================================================
  // register map (byte addresses)
  // =====================================================================
  localparam logic [11:0] CPT_OFS_CTRL0 = 12'h000;
  localparam logic [11:0] CPT_OFS_CTRL1 = 12'h004;
  localparam logic [11:0] CPT_OFS_COUNT = 12'h008;
  localparam logic [11:0] CPT_OFS_CMPA  = 12'h00C;
  localparam logic [11:0] CPT_OFS_FLAGS = 12'h010;

  // =====================================================================
  // timer_control_zero fields
  // =====================================================================
  localparam int CPT_C0_PRD_LSB = 0;
  localparam int CPT_C0_RUN_BIT = 3;
  localparam int CPT_C0_SEL_LSB = 4;

  // =====================================================================
  // timer_control_one fields
  // =====================================================================
  localparam int CPT_C1_CLR_BIT  = 0;
  localparam int CPT_C1_SWAP_BIT = 1;
  localparam int CPT_C1_INV_BIT  = 2;
  localparam int CPT_C1_INIT_BIT = 3;
  localparam int CPT_C1_ACT_LSB  = 4;
  localparam int CPT_C1_MODE_LSB = 6;

  // flags register fields
  localparam int CPT_FL_A_BIT = 0;
  localparam int CPT_FL_P_BIT = 1;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [6:0] CPT_RST_CTRL0 = 7'h00;
  localparam logic [7:0] CPT_RST_CTRL1 = 8'h00;
  localparam logic [9:0] CPT_RST_CMPA  = 10'h000;

  // =====================================================================
  // encodings
  // =====================================================================
  localparam logic [1:0] CPT_MODE_CMP   = 2'h0;
  localparam logic [1:0] CPT_MODE_UNDEF = 2'h1;
  localparam logic [1:0] CPT_MODE_PWM   = 2'h2;
  localparam logic [1:0] CPT_MODE_TMR   = 2'h3;

  localparam logic [1:0] CPT_ACT_NONE   = 2'h0;
  localparam logic [1:0] CPT_ACT_LOW    = 2'h1;
  localparam logic [1:0] CPT_ACT_HIGH   = 2'h2;
  localparam logic [1:0] CPT_ACT_TOGGLE = 2'h3;

  localparam logic [1:0] CPT_PWM_INACT  = 2'h0;
  localparam logic [1:0] CPT_PWM_ACT    = 2'h1;
  localparam logic [1:0] CPT_PWM_WAVE   = 2'h2;

  localparam logic [2:0] CPT_SEL_DIV4   = 3'h0;
  localparam logic [2:0] CPT_SEL_DIV1   = 3'h1;
  localparam logic [2:0] CPT_SEL_DIV16  = 3'h2;
  localparam logic [2:0] CPT_SEL_DIV64  = 3'h3;
  localparam logic [2:0] CPT_SEL_SUB_A  = 3'h4;
  localparam logic [2:0] CPT_SEL_SUB_B  = 3'h5;

  // largest 10-bit count and full 10-bit span
  localparam logic [9:0]  CPT_CNT_MAX   = 10'h3FF;
  localparam logic [10:0] CPT_FULL_SPAN = 11'h400;

endpackage

`default_nettype wire

// ### cpt_tick_gen.sv
/*
  Timer clock tick generator: a free-running prescaler on the bus clock
  and a synchronised, edge-detected slow sub clock from a pin.
  Assumes the sub clock is much slower than ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module cpt_tick_gen
  import cpt_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [2:0] clk_sel_i,
  input  wire logic       sub_clk_i,
  output logic            tick_o
);

  // =====================================================================
  // prescaler and synchroniser
  // =====================================================================
  logic [5:0] div_ff;
  logic [5:0] nxt_div;
  logic       sub_meta_ff;
  logic       sub_sync_ff;
  logic       sub_prev_ff;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb begin
    nxt_div = div_ff + 6'h01;
    unique case (clk_sel_i)
      CPT_SEL_DIV4:  nxt_tick = (div_ff[1:0] == 2'h3);
      CPT_SEL_DIV1:  nxt_tick = 1'b1;
      CPT_SEL_DIV16: nxt_tick = (div_ff[3:0] == 4'hF);
      CPT_SEL_DIV64: nxt_tick = (div_ff == 6'h3F);
      CPT_SEL_SUB_A,
      CPT_SEL_SUB_B: nxt_tick = sub_sync_ff & ~sub_prev_ff;
      // reserved selections give no tick at all
      default:       nxt_tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_ff      <= 6'h00;
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
      sub_prev_ff <= 1'b0;
      tick_ff     <= 1'b0;
    end else begin
      div_ff      <= nxt_div;
      sub_meta_ff <= sub_clk_i;
      sub_sync_ff <= sub_meta_ff;
      sub_prev_ff <= sub_sync_ff;
      tick_ff     <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule

`default_nettype wire

// ### cpt_timer.sv
/*
  Compact 10-bit timer with compare-match, timer/counter and edge-aligned
  PWM modes, two comparators, sticky match flags and one output pin,
  programmed over an APB slave.
  Assumes a single clock ref_clk_i and an APB3 master on the same clock.
*/
// Implementation choices: the register addresses and the APB slave port.
// Contract
// - mode field: 00 compare, 10 PWM, 11 timer, 01 undefined
// - compare mode, clear select low: clear on P match or overflow
// - clear select low: both A and P flags raised on matches
// - clear select high: clear on A match, only A flag raised
// - clear select high, A value zero: run to 3FF, no A flag
// - compare mode: only A matches change the pin
// - A match drives pin high, low, toggles, or leaves it
// - compare mode: run bit rising loads pin with initial level
// - timer mode counts like compare mode but leaves pin undriven
// - PWM mode ignores clear select; swap bit governs clearing
// - swap zero: P sets period value*128 or 1024, A sets duty
// - swap one: A sets period, P sets duty value*128 or 1024
// - duty at or above period gives full active level
// - PWM mode raises A and P flags on every match
// - initial level bit picks active level; action passes or forces
// - forced pin in PWM keeps counter and flags running
// - invert bit inverts the pin waveform
// - run rising clears counter, run falling freezes it
// - period value compared to counter bits 9 to 7
// - compare pin action: 00 none, 01 low, 10 high, 11 toggle
`timescale 1ns/1ps
`default_nettype none

module cpt_timer
  import cpt_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sub_clk_i,
  output logic             pin_o,
  output logic             pin_oe_n_o,
  output logic             match_a_flag_o,
  output logic             match_p_flag_o
);

  // =====================================================================
  // register state
  // =====================================================================
  logic [6:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [9:0]  cmpa_ff;
  logic        fla_ff;
  logic        flp_ff;
  logic [6:0]  nxt_ctrl0;
  logic [7:0]  nxt_ctrl1;
  logic [9:0]  nxt_cmpa;
  logic        nxt_fla;
  logic        nxt_flp;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        nxt_slverr;
  logic        wr_en;
  logic        hit;

  logic [2:0]  prd;
  logic        run;
  logic [2:0]  clk_sel;
  logic [1:0]  mode;
  logic [1:0]  act;
  logic        init_lvl;
  logic        inv;
  logic        swap;
  logic        clr_sel;

  assign prd      = ctrl0_ff[CPT_C0_PRD_LSB +: 3];
  assign run      = ctrl0_ff[CPT_C0_RUN_BIT];
  assign clk_sel  = ctrl0_ff[CPT_C0_SEL_LSB +: 3];
  assign mode     = ctrl1_ff[CPT_C1_MODE_LSB +: 2];
  assign act      = ctrl1_ff[CPT_C1_ACT_LSB +: 2];
  assign init_lvl = ctrl1_ff[CPT_C1_INIT_BIT];
  assign inv      = ctrl1_ff[CPT_C1_INV_BIT];
  assign swap     = ctrl1_ff[CPT_C1_SWAP_BIT];
  assign clr_sel  = ctrl1_ff[CPT_C1_CLR_BIT];

  // =====================================================================
  // counter state
  // =====================================================================
  logic [9:0]  cnt_ff;
  logic [9:0]  nxt_cnt;
  logic        run_prev_ff;
  logic        st_ff;
  logic        nxt_st;
  logic        pin_ff;
  logic        nxt_pin;
  logic        oe_n_ff;
  logic        nxt_oe_n;
  logic        tick;
  logic [9:0]  cnt_plus;
  logic        running;
  logic        run_rise;
  logic        raw_a;
  logic        raw_p;
  logic        ev_a;
  logic        ev_p;
  logic        set_a;
  logic        set_p;
  logic        clr;
  logic        is_pwm;
  logic [10:0] duty_len;
  logic        pwm_on;
  logic        pwm_lvl;

  cpt_tick_gen u_tick (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .clk_sel_i (clk_sel),
    .sub_clk_i (sub_clk_i),
    .tick_o    (tick)
  );

  // =====================================================================
  // APB slave: data latched at setup, answered in the first access cycle
  // =====================================================================
  assign wr_en = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;
  assign hit   = (paddr_i == CPT_OFS_CTRL0) | (paddr_i == CPT_OFS_CTRL1) |
                 (paddr_i == CPT_OFS_COUNT) | (paddr_i == CPT_OFS_CMPA)  |
                 (paddr_i == CPT_OFS_FLAGS);

  always_comb begin
    nxt_ctrl0  = ctrl0_ff;
    nxt_ctrl1  = ctrl1_ff;
    nxt_cmpa   = cmpa_ff;
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (psel_i && !penable_i) begin
      nxt_slverr = ~hit;
      unique case (paddr_i)
        CPT_OFS_CTRL0: nxt_prdata = {25'h0000000, ctrl0_ff};
        CPT_OFS_CTRL1: nxt_prdata = {24'h000000, ctrl1_ff};
        CPT_OFS_COUNT: nxt_prdata = {22'h000000, cnt_ff};
        CPT_OFS_CMPA:  nxt_prdata = {22'h000000, cmpa_ff};
        CPT_OFS_FLAGS: nxt_prdata = {30'h00000000, flp_ff, fla_ff};
        default:       nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr_i)
        CPT_OFS_CTRL0: nxt_ctrl0 = pwdata_i[6:0];
        CPT_OFS_CTRL1: nxt_ctrl1 = pwdata_i[7:0];
        CPT_OFS_CMPA:  nxt_cmpa  = pwdata_i[9:0];
        default:       nxt_cmpa  = cmpa_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl0_ff   <= CPT_RST_CTRL0;
      ctrl1_ff   <= CPT_RST_CTRL1;
      cmpa_ff    <= CPT_RST_CMPA;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl0_ff   <= nxt_ctrl0;
      ctrl1_ff   <= nxt_ctrl1;
      cmpa_ff    <= nxt_cmpa;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= psel_i & ~penable_i;
      pslverr_ff <= nxt_slverr;
    end
  end

  // =====================================================================
  // comparators and counter
  // =====================================================================
  assign is_pwm   = (mode == CPT_MODE_PWM);
  assign running  = run & run_prev_ff;
  assign run_rise = run & ~run_prev_ff;
  assign cnt_plus = cnt_ff + 10'h001;
  // period value against top three bits
  assign raw_p = (prd != 3'h0) && (cnt_plus[9:7] == prd) &&
                 (cnt_plus[6:0] == 7'h00);
  // zero A value never matches with clear select high outside PWM
  assign raw_a = (cnt_plus == cmpa_ff) &&
                 !(!is_pwm && clr_sel && cmpa_ff == 10'h000);
  assign ev_a  = tick & running & raw_a;
  assign ev_p  = tick & running & raw_p;

  always_comb begin
    // PWM clearing chosen by swap bit only
    if (is_pwm) begin
      clr = swap ? ev_a : ev_p;
    end else begin
      // clear source in compare and timer modes
      clr = clr_sel ? ev_a : ev_p;
    end
    if (run_rise) begin
      nxt_cnt = 10'h000;
    end else if (!running || !tick) begin
      nxt_cnt = cnt_ff;
    end else if (clr) begin
      nxt_cnt = 10'h000;
    end else begin
      nxt_cnt = cnt_plus;
    end
  end

  // =====================================================================
  // match flags: write one to clear, a new match wins over the clear
  // =====================================================================
  // both flags; no P flag with clear select high outside PWM
  assign set_a = ev_a;
  assign set_p = ev_p & (is_pwm | ~clr_sel);

  always_comb begin
    nxt_fla = fla_ff;
    nxt_flp = flp_ff;
    if (wr_en && paddr_i == CPT_OFS_FLAGS) begin
      nxt_fla = fla_ff & ~pwdata_i[CPT_FL_A_BIT];
      nxt_flp = flp_ff & ~pwdata_i[CPT_FL_P_BIT];
    end
    // flag one cycle after the match
    if (set_a) begin
      nxt_fla = 1'b1;
    end
    if (set_p) begin
      nxt_flp = 1'b1;
    end
  end

  // =====================================================================
  // output pin
  // =====================================================================
  always_comb begin
    // duty length from the swap bit
    if (!swap) begin
      duty_len = {1'b0, cmpa_ff};
    end else if (prd == 3'h0) begin
      duty_len = CPT_FULL_SPAN;
    end else begin
      duty_len = {1'b0, prd, 7'h00};
    end
    // active from clear until duty reached
    pwm_on = ({1'b0, nxt_cnt} < duty_len);
    unique case (act)
      CPT_PWM_ACT:  pwm_lvl = init_lvl;
      CPT_PWM_WAVE: pwm_lvl = pwm_on ? init_lvl : ~init_lvl;
      default:      pwm_lvl = ~init_lvl;
    endcase
    nxt_st = st_ff;
    if (run_rise) begin
      nxt_st = init_lvl;
    end else if (mode == CPT_MODE_CMP && ev_a) begin
      // only A matches act on the pin
      unique case (act)
        CPT_ACT_LOW:    nxt_st = 1'b0;
        CPT_ACT_HIGH:   nxt_st = 1'b1;
        CPT_ACT_TOGGLE: nxt_st = ~st_ff;
        CPT_ACT_NONE:   nxt_st = st_ff;
      endcase
    end
    // timer and undefined modes leave the pin free
    nxt_oe_n = ~(is_pwm | (mode == CPT_MODE_CMP));
    if (nxt_oe_n) begin
      nxt_pin = 1'b0;
    end else begin
      nxt_pin = (is_pwm ? pwm_lvl : nxt_st) ^ inv;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff      <= 10'h000;
      run_prev_ff <= 1'b0;
      fla_ff      <= 1'b0;
      flp_ff      <= 1'b0;
      st_ff       <= 1'b0;
      pin_ff      <= 1'b0;
      oe_n_ff     <= 1'b1;
    end else begin
      cnt_ff      <= nxt_cnt;
      run_prev_ff <= run;
      fla_ff      <= nxt_fla;
      flp_ff      <= nxt_flp;
      st_ff       <= nxt_st;
      pin_ff      <= nxt_pin;
      oe_n_ff     <= nxt_oe_n;
    end
  end

  assign prdata_o       = prdata_ff;
  assign pready_o       = pready_ff;
  assign pslverr_o      = pslverr_ff;
  assign pin_o          = pin_ff;
  assign pin_oe_n_o     = oe_n_ff;
  assign match_a_flag_o = fla_ff;
  assign match_p_flag_o = flp_ff;

  // =====================================================================
  // checks
  // =====================================================================
  a_flag_a_set: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ev_a |=> match_a_flag_o)
    else $error("A match did not raise the A flag");

  a_no_p_flag: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(match_p_flag_o) |-> $past(is_pwm) || !$past(clr_sel))
    else $error("P flag raised while A clears the counter");

  a_run_clears: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    run && !run_prev_ff |=> cnt_ff == 10'h000)
    else $error("counter not cleared on run rise");

  a_run_freeze: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !run ##1 !run |=> $stable(cnt_ff))
    else $error("counter moved while stopped");

  a_count_step: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    running && tick && !clr && run |=> cnt_ff == $past(cnt_ff) + 10'h001)
    else $error("counter did not step by one");

  a_clear_on_a: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !is_pwm && clr_sel && ev_a && run |=> cnt_ff == 10'h000)
    else $error("A match did not clear the counter");

  a_timer_free: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    mode == CPT_MODE_TMR |=> pin_oe_n_o)
    else $error("pin driven in timer mode");

  a_cmp_pin_hold: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    mode == CPT_MODE_CMP ##1 mode == CPT_MODE_CMP && !ev_a && !run_rise
    && $stable(inv) |=> $stable(pin_o))
    else $error("pin changed without an A match");

  a_pwm_forced: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    is_pwm && act == CPT_PWM_ACT |=> pin_o == $past(init_lvl ^ inv))
    else $error("forced active level not on pin");

  a_pwm_full: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    is_pwm && swap && act == CPT_PWM_WAVE && prd == 3'h0 && !inv
    |=> pin_o == $past(init_lvl))
    else $error("full duty did not hold active level");

endmodule

`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for cpt_timer: APB access tasks, then compare,
  timer, clock-select and PWM scenarios with expected values.
  Assumes cpt_pkg and the zero-wait APB slave of cpt_timer.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("MISMATCH t=%0t got %0h exp %0h", \
  $time, g, e); end end

module tb_top
  import cpt_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        sub_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        oe_n;
  logic        fa;
  logic        fp;
  logic [31:0] rv;
  logic        re;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;

  cpt_timer u_cpt_timer (
    .ref_clk_i      (clk),
    .arst_n_i       (rst_n),
    .psel_i         (psel),
    .penable_i      (pen),
    .pwrite_i       (pwr),
    .paddr_i        (paddr),
    .pwdata_i       (pwdata),
    .prdata_o       (prdata),
    .pready_o       (pready),
    .pslverr_o      (pslverr),
    .sub_clk_i      (sub_clk),
    .pin_o          (pin),
    .pin_oe_n_o     (oe_n),
    .match_a_flag_o (fa),
    .match_p_flag_o (fp)
  );

  // ======================================================================
  // clock, slow sub clock and hang guard
  // ======================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // sub clock rises every 16 cycles, far slower than the bus clock
  always @(posedge clk) begin
    cyc     <= cyc + 1;
    sub_clk <= cyc[3];
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ======================================================================
  // access tasks
  // ======================================================================
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one transfer; the trailing idle edge keeps strobes from re-rising
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // no wait-state limit here; a hang is left to the cycle guard
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rv, e);
  endtask

  // mode changes only while stopped, then flags cleared, then run
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
                     input logic [6:0] c0);
    wr(CPT_OFS_CTRL0, {25'h0, c0 & 7'h77});
    wr(CPT_OFS_CTRL1, {24'h0, c1});
    wr(CPT_OFS_CMPA, {22'h0, a});
    wr(CPT_OFS_FLAGS, 32'h3);
    wr(CPT_OFS_CTRL0, {25'h0, c0});
  endtask

  task automatic pin_is(input logic e);
    @(negedge clk);
    `CHK(pin, e);
    @(posedge clk);
  endtask

  // pin is sampled mid-cycle: high samples and level changes
  task automatic watch(input int len, output int h, output int t);
    logic last;
    h = 0;
    t = 0;
    @(negedge clk);
    last = pin;
    repeat (len) begin
      @(negedge clk);
      if (pin === 1'b1) h++;
      if (pin !== last) t++;
      last = pin;
    end
    @(posedge clk);
  endtask

  // ======================================================================
  // scenarios
  // ======================================================================
  logic [7:0] pc1 [8] = '{8'hA8, 8'hAC, 8'hA8, 8'hAA,
                          8'hA0, 8'h88, 8'h98, 8'hA9};
  logic [9:0] pa  [8] = '{10'h020, 10'h020, 10'h0C8, 10'h12C,
                          10'h020, 10'h020, 10'h020, 10'h020};
  int         per [8] = '{128, 128, 128, 300, 128, 128, 128, 128};
  int         ehi [8] = '{32, 96, 128, 128, 96, 0, 128, 32};
  logic [1:0] efl [8] = '{2'h3, 2'h3, 2'h2, 2'h3,
                          2'h3, 2'h3, 2'h3, 2'h3};
  // select 6 is reserved and must give no ticks at all
  logic [2:0] sl  [7] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  int         dv  [7] = '{1, 4, 16, 64, 16, 16, 100000};

  initial begin
    logic [1:0]  act;
    logic        ini;
    logic [31:0] prev;
    int          h;
    int          t;
    int          ex;
    rst_n  = 1'b0;
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(CPT_OFS_CTRL0, 32'h0);
    rd(CPT_OFS_CTRL1, 32'h0);
    rd(CPT_OFS_CMPA, 32'h0);
    rd(CPT_OFS_FLAGS, 32'h0);
    `CHK(oe_n, 1'b0);
    rd(12'h014, 32'h0);
    `CHK(re, 1'b1);
    wr(CPT_OFS_COUNT, 32'h155);
    rd(CPT_OFS_COUNT, 32'h0);

    // every pin action with both initial levels, clear on A match
    for (int i = 0; i < 8; i++) begin
      act = i[1:0];
      ini = i[2];
      cfg({2'b00, act, ini, 3'b001}, 10'h0C8, 7'h19);
      pin_is(ini);
      repeat (250) @(posedge clk);
      ex = (act == 2'h0) ? ini : (act == 2'h3) ? !ini : act[1];
      pin_is(ex[0]);
      `CHK({fp, fa}, 2'h1);
      `CHK(oe_n, 1'b0);
    end

    cfg(8'h01, 10'h000, 7'h18);
    repeat (1100) @(posedge clk);
    `CHK(fa, 1'b0);

    // clear on P match at 256, A toggles once per period
    cfg(8'h30, 10'h032, 7'h1A);
    repeat (20) @(posedge clk);
    watch(512, h, t);
    `CHK(t, 2);
    `CHK({fp, fa}, 2'h3);
    rd(CPT_OFS_FLAGS, 32'h3);
    apb(1'b0, CPT_OFS_COUNT, 32'h0);
    `CHK(rv[31:8], 24'h0);
    // undefined mode code releases the pin like timer mode
    wr(CPT_OFS_CTRL1, 32'h40);
    @(negedge clk);
    `CHK(oe_n, 1'b1);
    @(posedge clk);

    // timer mode, period value zero lets the count pass 512
    cfg(8'hC0, 10'h005, 7'h18);
    repeat (600) @(posedge clk);
    apb(1'b0, CPT_OFS_COUNT, 32'h0);
    `CHK(rv[9], 1'b1);
    `CHK(oe_n, 1'b1);
    `CHK(fa, 1'b1);

    // tick rates; the window allows for prescaler phase and bus latency
    for (int i = 0; i < 7; i++) begin
      cfg(8'hC1, 10'h000, {sl[i], 4'h8});
      repeat (512) @(posedge clk);
      wr(CPT_OFS_CTRL0, {25'h0, sl[i], 4'h0});
      apb(1'b0, CPT_OFS_COUNT, 32'h0);
      ex = 515 / dv[i];
      `CHK(rv + 3 >= ex && rv <= ex + 3, 1'b1);
      prev = rv;
      repeat (20) @(posedge clk);
      rd(CPT_OFS_COUNT, prev);
    end
    wr(CPT_OFS_CTRL0, {25'h0, 3'h1, 4'h8});
    apb(1'b0, CPT_OFS_COUNT, 32'h0);
    `CHK(rv < 8, 1'b1);

    // PWM table: one full period of samples gives the duty exactly
    for (int i = 0; i < 8; i++) begin
      cfg(pc1[i], pa[i], 7'h19);
      repeat (per[i] + 10) @(posedge clk);
      watch(per[i], h, t);
      `CHK(h, ehi[i]);
      rd(CPT_OFS_FLAGS, {30'h0, efl[i]});
      `CHK(oe_n, 1'b0);
    end
    // swap one, period value zero: a 1024-clock duty outlasts the period
    cfg(8'hAA, 10'h064, 7'h18);
    repeat (110) @(posedge clk);
    watch(100, h, t);
    `CHK(h, 100);
    `CHK(fa, 1'b1);
    give_verdict();
  end

endmodule

`default_nettype wire
